// ===== hdl/psw_defs.vh
`ifndef PSW_DEFS_VH
`define PSW_DEFS_VH

// Clock rate and time bases
`define PSW_CLK_HZ 20000000
`define PSW_TICK_US 1000
`define PSW_TICK_CYCLES (`PSW_CLK_HZ / 1000000 * `PSW_TICK_US)
`define PSW_SLOW_TICKS 7'd100

// Setting ranges, in setting units
`define PSW_SAMPLE_MIN_MS 14'd50
`define PSW_SAMPLE_MAX_MS 14'd9999
`define PSW_FILT_MAX_MS 14'd9999
`define PSW_DELAY_MAX 14'd9999
`define PSW_WAKE_DELAY_RST 14'd50
`define PSW_SLEEP_DELAY_RST 14'd100
`define PSW_SPEED_MAX 12'd4000
`define PSW_SPEED_OFF 12'd0
`define PSW_DEV_MAX 16'sd9999

// Controller enable and mode settings
`define PSW_EN_OFF 2'd0
`define PSW_MODE_MANUAL 2'd0
`define PSW_MODE_AUTO 2'd1
`define PSW_MODE_INPUT 2'd2

// Setpoint sources allowing automatic adjustment
`define PSW_SRC_LOCAL 2'd0
`define PSW_SRC_EPOT 2'd3

// Automatic adjustment select bit positions
`define PSW_ADJ_AUTO_BIT 0
`define PSW_ADJ_MAN_BIT 1

// Sequencer states
`define PSW_ST_OFF 3'd0
`define PSW_ST_SLEEP 3'd1
`define PSW_ST_RAMP 3'd2
`define PSW_ST_RUN 3'd3
`define PSW_ST_DECEL 3'd4
`define PSW_ST_DIRECT 3'd5

// Power-up settle cycles for the input synchronisers
`define PSW_INIT_CYCLES 2'd3

`endif

// ===== hdl/psw_delay_timer.v
`timescale 1ns/1ns
`include "psw_defs.vh"

module psw_delay_timer (
	input wire clock,
	input wire rst_b,
	input wire tick,
	input wire arm,
	input wire [13:0] limit,
	output reg done_ff
);

reg [13:0] count_ff;
reg [13:0] nxt_count;
reg nxt_done;

// Count restarts from zero whenever the condition drops
always @* begin
	nxt_count = count_ff;
	nxt_done = 1'b0;
	if (!arm) begin
		nxt_count = 14'h0000;
	end else if (count_ff >= limit) begin
		nxt_done = 1'b1;
	end else if (tick) begin
		nxt_count = count_ff + 14'h0001;
	end
end

always @(posedge clock) begin
	if (!rst_b) begin
		count_ff <= 14'h0000;
		done_ff <= 1'b0;
	end else begin
		count_ff <= nxt_count;
		done_ff <= nxt_done;
	end
end

endmodule

// ===== hdl/psw_ctrl.v
`timescale 1ns/1ns
`include "psw_defs.vh"


module psw_ctrl #(
	parameter TICK_CYCLES = `PSW_TICK_CYCLES
) (
	input wire clock,
	input wire rst_b,
	input wire run_stop_input,
	input wire manual_auto_select_input,
	input wire [1:0] controller_enable_setting,
	input wire [1:0] controller_mode_select,
	input wire [1:0] setpoint_source_select,
	input wire [1:0] setpoint_adjust_select,
	input wire reverse_action,
	input wire signed [15:0] setpoint_request,
	input wire signed [15:0] manual_setpoint_request,
	input wire signed [15:0] process_variable,
	input wire signed [15:0] wake_deviation,
	input wire [13:0] controller_sample_period,
	input wire [13:0] setpoint_filter_time_constant,
	input wire [13:0] wake_delay_time,
	input wire [13:0] sleep_delay_time,
	input wire [11:0] sleep_speed_threshold,
	input wire [11:0] minimum_speed_setting,
	input wire [11:0] motor_speed,
	output reg motor_run_ff,
	output reg ramp_to_min_ff,
	output reg decel_to_zero_ff,
	output reg pid_enable_ff,
	output reg pid_sample_ff,
	output reg pid_sleep_ff,
	output reg auto_mode_ff,
	output reg wake_condition_ff,
	output reg sleep_active_alarm,
	output reg signed [15:0] control_setpoint_ff,
	output reg signed [15:0] manual_setpoint_ff,
	output reg signed [15:0] filtered_setpoint_ff
);

////////////////////////////////////////////////////////////////
// Pin synchronisers: a change counts once stages two and three agree

reg [2:0] run_sync_ff;
reg [2:0] sel_sync_ff;
reg run_ff;
reg sel_ff;

always @(posedge clock) begin
	if (!rst_b) begin
		run_sync_ff <= 3'h0;
		sel_sync_ff <= 3'h0;
		run_ff <= 1'b0;
		sel_ff <= 1'b0;
	end else begin
		run_sync_ff <= {run_sync_ff[1:0], run_stop_input};
		sel_sync_ff <= {sel_sync_ff[1:0], manual_auto_select_input};
		if (run_sync_ff[1] == run_sync_ff[2]) begin
			run_ff <= run_sync_ff[2];
		end
		if (sel_sync_ff[1] == sel_sync_ff[2]) begin
			sel_ff <= sel_sync_ff[2];
		end
	end
end

////////////////////////////////////////////////////////////////
// Time bases: 1 ms tick and 100 ms tick

reg [15:0] div_ff;
reg ms_tick_ff;
reg [6:0] slow_ff;
reg slow_tick_ff;

always @(posedge clock) begin
	if (!rst_b) begin
		div_ff <= 16'h0000;
		ms_tick_ff <= 1'b0;
		slow_ff <= 7'h00;
		slow_tick_ff <= 1'b0;
	end else begin
		ms_tick_ff <= 1'b0;
		slow_tick_ff <= 1'b0;
		if (div_ff >= TICK_CYCLES[15:0] - 16'h0001) begin
			div_ff <= 16'h0000;
			ms_tick_ff <= 1'b1;
		end else begin
			div_ff <= div_ff + 16'h0001;
		end
		if (ms_tick_ff) begin
			if (slow_ff >= `PSW_SLOW_TICKS - 7'h01) begin
				slow_ff <= 7'h00;
				slow_tick_ff <= 1'b1;
			end else begin
				slow_ff <= slow_ff + 7'h01;
			end
		end
	end
end

////////////////////////////////////////////////////////////////
// Mode and enable decode

wire ctrl_enabled;
wire eff_auto;
wire src_adjustable;
wire sleep_allowed;

assign ctrl_enabled = (controller_enable_setting != `PSW_EN_OFF);
assign eff_auto = (controller_mode_select == `PSW_MODE_AUTO) ||
	((controller_mode_select == `PSW_MODE_INPUT) && sel_ff);
assign src_adjustable = (setpoint_source_select == `PSW_SRC_LOCAL) ||
	(setpoint_source_select == `PSW_SRC_EPOT);
// Zero threshold takes sleep out of the picture altogether
assign sleep_allowed = ctrl_enabled && eff_auto &&
	(sleep_speed_threshold != `PSW_SPEED_OFF);

////////////////////////////////////////////////////////////////
// Setpoint tracking with automatic adjustment on mode change

reg signed [15:0] sp_req_last_ff;
reg signed [15:0] man_req_last_ff;

always @(posedge clock) begin
	if (!rst_b) begin
		auto_mode_ff <= 1'b0;
		control_setpoint_ff <= 16'sh0000;
		manual_setpoint_ff <= 16'sh0000;
		sp_req_last_ff <= 16'sh0000;
		man_req_last_ff <= 16'sh0000;
	end else begin
		auto_mode_ff <= eff_auto;
		sp_req_last_ff <= setpoint_request;
		man_req_last_ff <= manual_setpoint_request;
		// A held value stays until software writes a new request
		if (!auto_mode_ff && eff_auto &&
			setpoint_adjust_select[`PSW_ADJ_AUTO_BIT] &&
			src_adjustable) begin
			control_setpoint_ff <= process_variable;
		end else if (setpoint_request != sp_req_last_ff) begin
			control_setpoint_ff <= setpoint_request;
		end
		if (auto_mode_ff && !eff_auto &&
			setpoint_adjust_select[`PSW_ADJ_MAN_BIT]) begin
			manual_setpoint_ff <= $signed({4'h0, motor_speed});
		end else if (manual_setpoint_request != man_req_last_ff) begin
			manual_setpoint_ff <= manual_setpoint_request;
		end
	end
end

////////////////////////////////////////////////////////////////
// Setpoint filter, updated each millisecond

// Gain is a power of two near 1/tau; trades accuracy for no divider
function [3:0] filt_shift;
	input [13:0] tc;
	integer i;
	begin
		filt_shift = 4'h0;
		for (i = 0; i < 14; i = i + 1) begin
			if (tc[i]) begin
				filt_shift = i[3:0];
			end
		end
	end
endfunction

wire signed [16:0] filt_err;
wire signed [16:0] filt_step;
wire signed [16:0] filt_sum;

assign filt_err = control_setpoint_ff - filtered_setpoint_ff;
assign filt_step = filt_err >>> filt_shift(setpoint_filter_time_constant);
assign filt_sum = filtered_setpoint_ff + filt_step;

always @(posedge clock) begin
	if (!rst_b) begin
		filtered_setpoint_ff <= 16'sh0000;
	end else if (setpoint_filter_time_constant == 14'h0000) begin
		filtered_setpoint_ff <= control_setpoint_ff;
	end else if (ms_tick_ff) begin
		if (filt_step == 17'sh0_0000) begin
			filtered_setpoint_ff <= control_setpoint_ff;
		end else begin
			filtered_setpoint_ff <= filt_sum[15:0];
		end
	end
end

////////////////////////////////////////////////////////////////
// Wake threshold and condition

wire signed [16:0] wake_thr;
wire wake_now;

assign wake_thr = reverse_action ?
	control_setpoint_ff + wake_deviation :
	control_setpoint_ff - wake_deviation;
assign wake_now = reverse_action ?
	($signed({process_variable[15], process_variable}) > wake_thr) :
	($signed({process_variable[15], process_variable}) < wake_thr);

always @(posedge clock) begin
	if (!rst_b) begin
		wake_condition_ff <= 1'b0;
	end else begin
		wake_condition_ff <= wake_now;
	end
end

////////////////////////////////////////////////////////////////
// Wake and sleep delay timers

reg [2:0] state_ff;
reg [2:0] nxt_state;
wire wake_done;
wire sleep_done;
wire slow_speed;

assign slow_speed = (motor_speed < sleep_speed_threshold);

psw_delay_timer u_wake_timer (
	.clock(clock),
	.rst_b(rst_b),
	.tick(slow_tick_ff),
	.arm((state_ff == `PSW_ST_SLEEP) && wake_condition_ff),
	.limit(wake_delay_time),
	.done_ff(wake_done)
);

psw_delay_timer u_sleep_timer (
	.clock(clock),
	.rst_b(rst_b),
	.tick(slow_tick_ff),
	.arm((state_ff == `PSW_ST_RUN) && slow_speed),
	.limit(sleep_delay_time),
	.done_ff(sleep_done)
);

////////////////////////////////////////////////////////////////
// Sleep and wake sequencer

reg [1:0] init_ff;
reg init_done_ff;
reg first_ff;

// Power-up check waits until the run pin has cleared its synchroniser
always @(posedge clock) begin
	if (!rst_b) begin
		init_ff <= 2'h0;
		init_done_ff <= 1'b0;
		first_ff <= 1'b1;
	end else if (init_ff != `PSW_INIT_CYCLES) begin
		init_ff <= init_ff + 2'h1;
	end else if (!init_done_ff) begin
		init_done_ff <= 1'b1;
	end else begin
		first_ff <= 1'b0;
	end
end

always @* begin
	nxt_state = state_ff;
	case (state_ff)
	`PSW_ST_OFF: begin
		if (!init_done_ff) begin
			nxt_state = `PSW_ST_OFF;
		end else if (run_ff && !sleep_allowed) begin
			nxt_state = `PSW_ST_DIRECT;
		end else if (run_ff && first_ff && wake_condition_ff) begin
			nxt_state = `PSW_ST_RAMP;
		end else if (run_ff) begin
			nxt_state = `PSW_ST_SLEEP;
		end
	end
	`PSW_ST_SLEEP: begin
		if (!run_ff) begin
			nxt_state = `PSW_ST_OFF;
		end else if (!sleep_allowed) begin
			nxt_state = `PSW_ST_DIRECT;
		end else if (wake_done) begin
			nxt_state = `PSW_ST_RAMP;
		end
	end
	`PSW_ST_RAMP: begin
		if (!run_ff) begin
			nxt_state = `PSW_ST_OFF;
		end else if (motor_speed >= minimum_speed_setting) begin
			nxt_state = `PSW_ST_RUN;
		end
	end
	`PSW_ST_RUN: begin
		if (!run_ff) begin
			nxt_state = `PSW_ST_OFF;
		end else if (!sleep_allowed) begin
			nxt_state = `PSW_ST_DIRECT;
		end else if (sleep_done) begin
			nxt_state = `PSW_ST_DECEL;
		end
	end
	`PSW_ST_DECEL: begin
		if (!run_ff) begin
			nxt_state = `PSW_ST_OFF;
		end else if (motor_speed == `PSW_SPEED_OFF) begin
			nxt_state = `PSW_ST_SLEEP;
		end
	end
	`PSW_ST_DIRECT: begin
		if (!run_ff) begin
			nxt_state = `PSW_ST_OFF;
		end else if (sleep_allowed) begin
			nxt_state = `PSW_ST_RUN;
		end
	end
	default: begin
		nxt_state = `PSW_ST_OFF;
	end
	endcase
end

always @(posedge clock) begin
	if (!rst_b) begin
		state_ff <= `PSW_ST_OFF;
	end else begin
		state_ff <= nxt_state;
	end
end

////////////////////////////////////////////////////////////////
// Motor and controller commands

always @(posedge clock) begin
	if (!rst_b) begin
		motor_run_ff <= 1'b0;
		ramp_to_min_ff <= 1'b0;
		decel_to_zero_ff <= 1'b0;
		pid_enable_ff <= 1'b0;
		pid_sleep_ff <= 1'b0;
		sleep_active_alarm <= 1'b0;
	end else begin
		motor_run_ff <= (nxt_state == `PSW_ST_RAMP) ||
			(nxt_state == `PSW_ST_RUN) ||
			(nxt_state == `PSW_ST_DIRECT);
		ramp_to_min_ff <= (nxt_state == `PSW_ST_RAMP);
		decel_to_zero_ff <= (nxt_state == `PSW_ST_DECEL);
		pid_enable_ff <= ((nxt_state == `PSW_ST_RUN) ||
			(nxt_state == `PSW_ST_DIRECT)) && ctrl_enabled;
		pid_sleep_ff <= (nxt_state == `PSW_ST_SLEEP);
		sleep_active_alarm <= (nxt_state == `PSW_ST_SLEEP) ||
			(nxt_state == `PSW_ST_DECEL);
	end
end

////////////////////////////////////////////////////////////////
// Controller sample strobe

reg [13:0] samp_ff;
wire [13:0] samp_period;

// Settings below the range minimum are held at the minimum
assign samp_period = (controller_sample_period < `PSW_SAMPLE_MIN_MS) ?
	`PSW_SAMPLE_MIN_MS : controller_sample_period;

always @(posedge clock) begin
	if (!rst_b) begin
		samp_ff <= 14'h0000;
		pid_sample_ff <= 1'b0;
	end else begin
		pid_sample_ff <= 1'b0;
		if (!pid_enable_ff) begin
			samp_ff <= 14'h0000;
		end else if (ms_tick_ff) begin
			if (samp_ff >= samp_period - 14'h0001) begin
				samp_ff <= 14'h0000;
				pid_sample_ff <= 1'b1;
			end else begin
				samp_ff <= samp_ff + 14'h0001;
			end
		end
	end
end

endmodule

// ===== sim/psw_ctrl_asserts.sv
`timescale 1ns/1ns
module psw_ctrl_asserts #(
	parameter TICK_CYCLES = 20000
) (
	input wire clock,
	input wire rst_b,
	input wire [1:0] controller_enable_setting,
	input wire [1:0] controller_mode_select,
	input wire [13:0] wake_delay_time,
	input wire [13:0] sleep_delay_time,
	input wire [11:0] sleep_speed_threshold,
	input wire [11:0] minimum_speed_setting,
	input wire [11:0] motor_speed,
	input wire motor_run_ff,
	input wire ramp_to_min_ff,
	input wire decel_to_zero_ff,
	input wire pid_enable_ff,
	input wire pid_sleep_ff,
	input wire auto_mode_ff,
	input wire wake_condition_ff,
	input wire sleep_active_alarm
);
	// Held-run counters; only lower bounds here, upper bounds in bench
	logic [31:0] w_ff, wl_ff, s_ff, sl_ff;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	always @(posedge clock) begin
		if (!rst_b) begin
			{w_ff, wl_ff, s_ff, sl_ff} <= '0;
		end else begin
			w_ff <= wake_condition_ff ? w_ff + 1 : '0;
			s_ff <= motor_speed < sleep_speed_threshold ? s_ff + 1 : '0;
			wl_ff <= w_ff;
			sl_ff <= s_ff;
		end
	end
	////////////////////////////////////////
	property p_alarm;
		pid_sleep_ff || decel_to_zero_ff |->
			sleep_active_alarm && !motor_run_ff && !pid_enable_ff;
	endproperty
	a_alarm: assert property (p_alarm) else $error("alarm");
	property p_ramp_end;
		$fell(ramp_to_min_ff) && motor_run_ff |->
			$past(motor_speed) >= minimum_speed_setting && pid_enable_ff;
	endproperty
	a_ramp_end: assert property (p_ramp_end) else $error("ramp");
	property p_stop;
		$rose(pid_sleep_ff) && $past(decel_to_zero_ff) |->
			$past(motor_speed) == 12'h000;
	endproperty
	a_stop: assert property (p_stop) else $error("stop");
	property p_thr_off;
		sleep_speed_threshold == 12'h000 && pid_sleep_ff |=> !pid_sleep_ff;
	endproperty
	a_thr_off: assert property (p_thr_off) else $error("thr");
	property p_not_auto;
		(controller_enable_setting == 2'h0 ||
			controller_mode_select == 2'h0) && pid_sleep_ff
			|-> ##[1:2] !pid_sleep_ff;
	endproperty
	a_not_auto: assert property (p_not_auto) else $error("auto");
	property p_mode;
		controller_mode_select != 2'h2 && controller_enable_setting != 2'h0
			##1 controller_enable_setting != 2'h0 |->
			auto_mode_ff == ($past(controller_mode_select) == 2'h1);
	endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_wake_time;
		$rose(ramp_to_min_ff) && $past(pid_sleep_ff) &&
			wake_delay_time > 14'h1 |->
			wl_ff >= (wake_delay_time - 1) * 100 * TICK_CYCLES;
	endproperty
	a_wake_time: assert property (p_wake_time) else $error("wake");
	property p_sleep_time;
		$rose(decel_to_zero_ff) && sleep_delay_time > 14'h1 |->
			sl_ff >= (sleep_delay_time - 1) * 100 * TICK_CYCLES;
	endproperty
	a_sleep_time: assert property (p_sleep_time) else $error("slp");
endmodule

bind psw_ctrl psw_ctrl_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
	.clock, .rst_b, .controller_enable_setting, .controller_mode_select,
	.wake_delay_time, .sleep_delay_time, .sleep_speed_threshold,
	.minimum_speed_setting, .motor_speed, .motor_run_ff, .ramp_to_min_ff,
	.decel_to_zero_ff, .pid_enable_ff, .pid_sleep_ff, .auto_mode_ff,
	.wake_condition_ff, .sleep_active_alarm
);

// ===== sim/psw_motor_model.sv
`timescale 1ns/1ns
module psw_motor_model (
	input wire clock,
	input wire ramp_to_min_ff,
	input wire pid_enable_ff,
	input wire [11:0] minimum_speed_setting,
	input wire [11:0] demand,
	input wire [11:0] step,
	output logic [11:0] motor_speed
);
	// Slews by step per cycle; a small step gives a slow drive
	logic [11:0] goal, speed_ff = 12'h000;
	assign goal = ramp_to_min_ff ? minimum_speed_setting :
		pid_enable_ff ? demand : 12'h000;
	assign motor_speed = speed_ff;
	always @(posedge clock) begin
		if (speed_ff + step < goal)
			speed_ff <= speed_ff + step;
		else if (speed_ff > goal + step)
			speed_ff <= speed_ff - step;
		else
			speed_ff <= goal;
	end
endmodule

// ===== sim/psw_ctrl_tb.sv
`timescale 1ns/1ns
module psw_ctrl_tb;
	logic clock = 0, rst_b = 0, run_stop_input = 1, w;
	logic manual_auto_select_input = 1, reverse_action = 0;
	logic [1:0] controller_enable_setting = 2'h1;
	logic [1:0] controller_mode_select = 2'h1;
	logic [1:0] setpoint_source_select = 2'h0;
	logic [1:0] setpoint_adjust_select = 2'h0;
	logic signed [15:0] setpoint_request = 16'h1388;
	logic signed [15:0] manual_setpoint_request = 16'h0000;
	logic signed [15:0] process_variable = 16'h0000;
	logic signed [15:0] wake_deviation = 16'h0064;
	logic [13:0] controller_sample_period = 14'h0032;
	logic [13:0] setpoint_filter_time_constant = 14'h0000;
	logic [13:0] wake_delay_time = 14'h0003, sleep_delay_time = 14'h0002;
	logic [11:0] sleep_speed_threshold = 12'h12c;
	logic [11:0] minimum_speed_setting = 12'h0c8;
	logic [11:0] demand = 12'h1f4, step = 12'h004, motor_speed;
	logic motor_run_ff, ramp_to_min_ff, decel_to_zero_ff, pid_enable_ff;
	logic pid_sample_ff, pid_sleep_ff, auto_mode_ff, wake_condition_ff;
	logic sleep_active_alarm;
	logic signed [15:0] control_setpoint_ff, manual_setpoint_ff;
	logic signed [15:0] filtered_setpoint_ff;
	logic [15:0] e;
	logic [31:0] lfsr = 32'h0000_4c85;
	int miscompares = 0, n_compared = 0, c;

	psw_ctrl #(.TICK_CYCLES(20)) dut (.*);
	psw_motor_model partner (.*);
	initial forever #25 clock = ~clock;
	////////////////////////////////////////
	task automatic conclude;
		if (miscompares == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] x, g);
		n_compared++;
		if (g !== x) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", nm, x, g);
		end
	endtask
	function automatic logic pick(input int k);
		case (k)
			0: return motor_run_ff;
			1: return pid_sleep_ff;
			2: return pid_enable_ff;
			3: return decel_to_zero_ff;
			default: return pid_sample_ff;
		endcase
	endfunction
	// Bounded wait at falling edges; a timeout ends the run
	task automatic await(input int k, input int n);
		c = 0;
		while (pick(k) !== 1'b1 && c < n) begin
			@(negedge clock);
			c++;
		end
		chk("wait", 1'b1, pick(k));
		if (pick(k) !== 1'b1)
			conclude;
	endtask
	function automatic logic wk(input int p, d, r);
		return r ? p > setpoint_request + d : p < setpoint_request - d;
	endfunction
	function automatic logic [31:0] nx(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	////////////////////////////////////////
	initial begin
		repeat (16) @(negedge clock);
		rst_b = 1;
		await(0, 20);
		chk("ramp", 1'b1, ramp_to_min_ff);
		chk("pid", 1'b0, pid_enable_ff);
		await(2, 200);
		process_variable = 16'h1388;
		demand = 12'h064;
		repeat (1000) @(negedge clock);
		demand = 12'h1f4;
		repeat (100) @(negedge clock);
		demand = 12'h064;
		await(3, 4200);
		chk("early", 1'b1, c > 1900);
		chk("run", 1'b0, motor_run_ff);
		await(1, 200);
		chk("alarm", 1'b1, sleep_active_alarm);
		repeat (24) begin
			lfsr = nx(lfsr);
			reverse_action = lfsr[0];
			process_variable = 16'h12c0 + lfsr[9:1];
			wake_deviation = {9'h000, lfsr[16:10]};
			w = wk(process_variable, wake_deviation, reverse_action);
			repeat (3) @(negedge clock);
			chk("wake", w, wake_condition_ff);
		end
		// Slow drive from here on, to stretch the ramp
		reverse_action = 0;
		wake_deviation = 16'h0064;
		step = 12'h001;
		process_variable = 16'h0000;
		repeat (3500) @(negedge clock);
		chk("asleep", 1'b0, motor_run_ff);
		process_variable = 16'h1388;
		repeat (10) @(negedge clock);
		process_variable = 16'h0000;
		await(0, 6500);
		chk("restart", 1'b1, c > 3900);
		chk("ramp", 1'b1, ramp_to_min_ff);
		process_variable = 16'h1388;
		await(2, 400);
		for (int i = 0; i < 4; i++) begin
			await(1, 6000);
			case (i)
				0: sleep_speed_threshold = 12'h000;
				1: controller_mode_select = 2'h0;
				2: controller_enable_setting = 2'h0;
				default: begin
					controller_mode_select = 2'h2;
					manual_auto_select_input = 0;
				end
			endcase
			await(0, 20);
			chk("alarm", 1'b0, sleep_active_alarm);
			sleep_speed_threshold = 12'h12c;
			controller_mode_select = 2'h1;
			controller_enable_setting = 2'h1;
			manual_auto_select_input = 1;
		end
		process_variable = 16'h0bb8;
		setpoint_adjust_select = 2'h1;
		for (int s = 0; s < 4; s++) begin
			controller_mode_select = 2'h0;
			setpoint_source_select = s[1:0];
			setpoint_request = 16'h1388 + s[15:0];
			repeat (5) @(negedge clock);
			controller_mode_select = 2'h1;
			repeat (5) @(negedge clock);
			e = (s % 3 == 0) ? process_variable : setpoint_request;
			chk("adjust", e, control_setpoint_ff);
			chk("filt", e, filtered_setpoint_ff);
		end
		manual_setpoint_request = 16'h0123;
		repeat (3) @(negedge clock);
		chk("manual", 16'h0123, manual_setpoint_ff);
		// Leaving automatic loads the present speed as manual setpoint
		setpoint_adjust_select = 2'h2;
		controller_mode_select = 2'h0;
		e = {4'h0, motor_speed};
		repeat (3) @(negedge clock);
		chk("manual", e, manual_setpoint_ff);
		// Below the minimum the period is held at 50 ms (1000 cycles)
		controller_sample_period = 14'h000a;
		for (int p = 0; p < 2; p++) begin
			repeat (2) begin
				await(4, 2100);
				@(negedge clock);
			end
			await(4, 2100);
			chk("period", p ? 16'h07cf : 16'h03e7, c[15:0]);
			controller_sample_period = 14'h0064;
		end
		setpoint_filter_time_constant = 14'h0010;
		setpoint_request = 16'h1388;
		repeat (2) @(negedge clock);
		chk("filt", 1'b0, filtered_setpoint_ff == 16'h1388);
		repeat (8000) @(negedge clock);
		chk("filt", 16'h1388, filtered_setpoint_ff);
		conclude;
	end
endmodule
